// file: rtl/dsps_pkg.sv
// Constants, types and state layout for one slot of the dual-slot power sequencer.
// Assumes a single 100 MHz logic clock; all analog indications arrive as digital levels.
package dsps_pkg;

   // Clock rate and filter times
   localparam int CLK_MHZ       = 100;              // Logic clock in MHz
   localparam int T_BREAKER_US  = 20;               // Breaker persistence time
   localparam int T_INPUT_UV_US = 18;               // Input supply lockout filter
   localparam int T_VCC_UV_US   = 38;               // Device supply lockout filter
   localparam int T_PG_BAD_US   = 20;               // Output-not-good filter

   // Cycle counts derived from the times (the filters trip after the count is reached)
   localparam int CNT_W = 12;                       // Counter width, holds every count below
   localparam logic [CNT_W-1:0] BRK_CYC = CNT_W'(T_BREAKER_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] UV_CYC  = CNT_W'(T_INPUT_UV_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] VCC_CYC = CNT_W'(T_VCC_UV_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] PG_CYC  = CNT_W'(T_PG_BAD_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

   // Filter counter indices
   localparam int NCNT  = 9;
   localparam int C_B12 = 0;                        // 12V breaker
   localparam int C_B3  = 1;                        // 3.3V breaker
   localparam int C_BAX = 2;                        // Aux breaker
   localparam int C_L12 = 3;                        // 12V input lockout
   localparam int C_L3  = 4;                        // 3.3V input lockout
   localparam int C_LAX = 5;                        // Aux input lockout
   localparam int C_LVC = 6;                        // Device supply lockout
   localparam int C_PGM = 7;                        // Main output not good
   localparam int C_PGA = 8;                        // Aux output not good

   // Analog front-end indications, all active high
   typedef struct packed {
      logic brk12;                                  // 12V breaker comparator over threshold
      logic brk3;                                   // 3.3V breaker comparator over threshold
      logic brkaux;                                 // Aux current above breaker level
      logic hot;                                    // Aux switch at shutdown temperature
      logic cool;                                   // Aux switch below restart temperature
      logic low12;                                  // 12V input below lockout
      logic low3;                                   // 3.3V input below lockout
      logic lowaux;                                 // Aux input below lockout
      logic lowvcc;                                 // Device supply below lockout
      logic good12;                                 // 12V output above good threshold
      logic good3;                                  // 3.3V output above good threshold
      logic goodaux;                                // Aux output above good threshold
   } dsps_ana_s;

   // Slot outputs
   typedef struct packed {
      logic main_gate_on;                           // Both main external switches on
      logic aux_switch_on;                          // Internal aux switch on
      logic main_discharge;                         // Main output pull-down active
      logic aux_discharge;                          // Aux output pull-down active
      logic main_trip_flag_n;                       // Main fault flag, low active
      logic aux_trip_flag_n;                        // Aux fault flag, low active
      logic main_output_ok_n;                       // Main power good, low active
      logic aux_output_ok_n;                        // Aux power good, low active
   } dsps_out_s;

   // Whole state of the slot
   typedef struct packed {
      dsps_ana_s                     sync1;         // First synchroniser stage
      dsps_ana_s                     sync2;         // Second synchroniser stage
      logic [NCNT-1:0][CNT_W-1:0]    cnt;           // Filter counters
      logic                          main_trip;     // Main breaker latch
      logic                          aux_trip;      // Aux breaker/thermal latch
      logic                          therm_lock;    // Thermal restart lock
      logic                          therm_req_low; // Aux request seen low since thermal trip
      logic                          main_armed;    // Main breaker armed
      logic                          aux_armed;     // Aux breaker armed
      logic                          exit_hold;     // Leaving current-limit force mode
      logic                          main_req_d;    // Previous main request
      logic                          aux_req_d;     // Previous aux request
      dsps_out_s                     out;           // Registered outputs
   } dsps_state_s;

endpackage

// file: rtl/dsps_slot.sv
// One slot of a dual-slot live-insertion power sequencer: gating, filtering, fault latches, status.
// Assumes control inputs are synchronous to core_clk and comparator results are asynchronous levels.
//
// Behaviour
// - Main breaker over 20us trips both mains
// - Aux breaker over 20us trips aux switch
// - Main trip spares aux; aux trip spares mains
// - Over-temperature shuts aux switch, latches aux flag
// - Thermal restart needs request recycle while cool, or a device supply lockout
// - Input lockout over 18us drops its group
// - Device supply lockout over 38us drops all
// - Restart only with all relevant supplies good
// - Groups start independently on request high
// - Breaker armed once input clears lockout
// - Power good low only when all conditions hold
// - Output low over 20us releases power good
// - Request low or card removed drops switches
// - Off switch discharges output, releases power good
// - Force override turns mains on except in device supply lockout; aux also needs no heat, thermal lock or current-limit trip
// - Trip latches clear on request low or lockout
// - Force override blocks every latch clear except the thermal lock's release by request recycle
// - Force with card low flags faults unlatched, keeps trip latches
// - Force with card high: unfiltered breaker mode
`timescale 1ns/1ps
`default_nettype none

module dsps_slot
   import dsps_pkg::*;
(
   // Clock, reset and clock enable
   input  wire logic      core_clk,
   input  wire logic      rst,
   input  wire logic      clk_en,
   // Control from the hot plug controller
   input  wire logic      card_inserted_n,
   input  wire logic      main_power_request,
   input  wire logic      aux_power_request,
   input  wire logic      force_override,
   // Analog front-end indications
   input  wire dsps_ana_s ana,
   // Switch, discharge and status outputs
   output var  dsps_out_s slot_out
);

   dsps_state_s st;       // Registered state
   dsps_state_s next_st;  // Next state

   // Advance a filter counter: count while the condition holds, saturate at the limit, restart on release
   function automatic logic [CNT_W-1:0] filt_step(input logic [CNT_W-1:0] c, input logic cond,
                                                  input logic [CNT_W-1:0] lim);
      logic [CNT_W-1:0] r;
      r = CNT_ZERO;
      if (!cond) begin
         r = CNT_ZERO;
      end else if (c < lim) begin
         r = c + CNT_W'(1);
      end else begin
         r = lim;
      end
      return r;
   endfunction

   // Combinational next-state logic
   always_comb begin
      dsps_ana_s s;          // Synchronised indications
      logic      fmode;      // Forced-on diagnostic mode
      logic      cmode;      // Forced-on current-limit mode
      logic      force_any;  // Any force mode
      logic      vcc_lock;   // Device supply lockout expired
      logic      main_uv;    // Main input lockout expired
      logic      aux_uv;     // Aux input lockout expired
      logic      main_in_ok; // Main inputs and device supply above lockout
      logic      aux_in_ok;  // Aux input and device supply above lockout
      logic      brk_main;   // Main breaker trip, filtered except in current-limit mode
      logic      brk_aux;    // Aux breaker trip, filtered except in current-limit mode
      logic      start_ok;   // Card present and no exit hold
      logic      main_on;
      logic      aux_on;
      next_st = st;
      s = st.sync2;
      // Defaults so no local carries a value over from an earlier pass
      fmode      = 1'b0;
      cmode      = 1'b0;
      force_any  = 1'b0;
      vcc_lock   = 1'b0;
      main_uv    = 1'b0;
      aux_uv     = 1'b0;
      main_in_ok = 1'b0;
      aux_in_ok  = 1'b0;
      brk_main   = 1'b0;
      brk_aux    = 1'b0;
      start_ok   = 1'b0;
      main_on    = 1'b0;
      aux_on     = 1'b0;

      // Two-stage synchroniser; only the second stage feeds the logic
      next_st.sync1 = ana;
      next_st.sync2 = st.sync1;

      fmode     = force_override && !card_inserted_n;
      cmode     = force_override && card_inserted_n;
      force_any = force_override;

      // Filter counters
      next_st.cnt[C_B12] = filt_step(st.cnt[C_B12], s.brk12 && st.main_armed, BRK_CYC);
      next_st.cnt[C_B3]  = filt_step(st.cnt[C_B3], s.brk3 && st.main_armed, BRK_CYC);
      next_st.cnt[C_BAX] = filt_step(st.cnt[C_BAX], s.brkaux && st.aux_armed, BRK_CYC);
      next_st.cnt[C_L12] = filt_step(st.cnt[C_L12], s.low12, UV_CYC);
      next_st.cnt[C_L3]  = filt_step(st.cnt[C_L3], s.low3, UV_CYC);
      next_st.cnt[C_LAX] = filt_step(st.cnt[C_LAX], s.lowaux, UV_CYC);
      next_st.cnt[C_LVC] = filt_step(st.cnt[C_LVC], s.lowvcc, VCC_CYC);
      next_st.cnt[C_PGM] = filt_step(st.cnt[C_PGM], !(s.good12 && s.good3), PG_CYC);
      next_st.cnt[C_PGA] = filt_step(st.cnt[C_PGA], !s.goodaux, PG_CYC);

      // Lockout decisions from the filtered counts, input-ok from the raw levels
      vcc_lock = (st.cnt[C_LVC] == VCC_CYC);
      main_uv  = (st.cnt[C_L12] == UV_CYC) || (st.cnt[C_L3] == UV_CYC);
      aux_uv   = (st.cnt[C_LAX] == UV_CYC);
      main_in_ok = !s.low12 && !s.low3 && !s.lowvcc;
      aux_in_ok  = !s.lowaux && !s.lowvcc;

      // Breakers arm once their input clears lockout and disarm in lockout
      next_st.main_armed = !s.low12 && !s.low3;
      next_st.aux_armed  = !s.lowaux;

      // Current-limit force mode bypasses the persistence filter
      if (cmode) begin
         brk_main = st.main_armed && (s.brk12 || s.brk3);
         brk_aux  = st.aux_armed && s.brkaux;
      end else begin
         brk_main = (st.cnt[C_B12] == BRK_CYC) || (st.cnt[C_B3] == BRK_CYC);
         brk_aux  = (st.cnt[C_BAX] == BRK_CYC);
      end

      // Main latch: set wins over clear; force freezes the contents
      if (!force_any) begin
         if (brk_main) begin
            next_st.main_trip = 1'b1;
         end else if (!main_power_request || main_uv || vcc_lock) begin
            next_st.main_trip = 1'b0;
         end
      end

      // Aux latch: breaker or thermal; may still set in current-limit force mode
      if (!force_any || cmode) begin
         if (brk_aux || (s.hot && !fmode)) begin
            next_st.aux_trip = 1'b1;
         end else if (!force_any && (!aux_power_request || aux_uv || vcc_lock)) begin
            next_st.aux_trip = 1'b0;
         end
      end

      // Thermal lock: released by request low then high while cool, or by device supply lockout below
      if (s.hot) begin
         next_st.therm_lock    = 1'b1;
         next_st.therm_req_low = 1'b0;
      end else if (st.therm_lock) begin
         if (!aux_power_request) begin
            next_st.therm_req_low = 1'b1;
         end else if (st.therm_req_low && !st.aux_req_d && s.cool) begin
            next_st.therm_lock    = 1'b0;
            next_st.therm_req_low = 1'b0;
         end
      end
      // A switch that is still hot keeps its lock: the set wins over the clear
      if (vcc_lock && !force_any && !s.hot) begin
         next_st.therm_lock = 1'b0;
      end

      // Leaving current-limit force mode needs both inputs low and both requests recycled
      if (cmode) begin
         next_st.exit_hold = 1'b1;
      end else if (st.exit_hold && !force_override && !card_inserted_n
                   && !main_power_request && !aux_power_request) begin
         next_st.exit_hold = 1'b0;
      end

      next_st.main_req_d = main_power_request;
      next_st.aux_req_d  = aux_power_request;

      // Switch control
      start_ok = !card_inserted_n && !st.exit_hold;
      if (vcc_lock) begin
         main_on = 1'b0;
         aux_on  = 1'b0;
      end else if (force_any) begin
         main_on = 1'b1;
         aux_on  = !s.hot && !st.therm_lock && !(cmode && st.aux_trip);
      end else begin
         // Request level covers both already-high and rising-edge starts
         // Raw lockout only blocks a fresh start; a running group rides out a dip until its filter expires
         main_on = start_ok && main_power_request && (main_in_ok || st.out.main_gate_on) && !main_uv
                   && !st.main_trip && !brk_main;
         aux_on  = start_ok && aux_power_request && (aux_in_ok || st.out.aux_switch_on) && !aux_uv
                   && !st.aux_trip && !brk_aux && !s.hot && !st.therm_lock;
      end
      next_st.out.main_gate_on   = main_on;
      next_st.out.aux_switch_on  = aux_on;
      next_st.out.main_discharge = !main_on;
      next_st.out.aux_discharge  = !aux_on;

      // Fault flags: latched normally, unlatched comparator view under diagnostic force
      if (fmode) begin
         next_st.out.main_trip_flag_n = !(st.main_trip || (st.main_armed && (s.brk12 || s.brk3)));
         next_st.out.aux_trip_flag_n  = !(st.aux_trip || (st.aux_armed && s.brkaux));
      end else if (cmode) begin
         next_st.out.main_trip_flag_n = !(st.main_trip || brk_main);
         next_st.out.aux_trip_flag_n  = aux_on;
      end else begin
         next_st.out.main_trip_flag_n = !next_st.main_trip;
         next_st.out.aux_trip_flag_n  = !next_st.aux_trip;
      end

      // Power good: pull low only when every condition holds, release on a 20us low output
      if (main_on && !card_inserted_n && main_in_ok && main_power_request
          && s.good12 && s.good3 && !force_any) begin
         next_st.out.main_output_ok_n = 1'b0;
      // A short input dip holds the status; only an expired lockout releases it
      end else if (!main_on || card_inserted_n || main_uv || !main_power_request
                   || (st.cnt[C_PGM] == PG_CYC) || force_any) begin
         next_st.out.main_output_ok_n = 1'b1;
      end
      if (aux_on && !card_inserted_n && aux_in_ok && aux_power_request
          && s.goodaux && !s.hot && !st.therm_lock && !force_any) begin
         next_st.out.aux_output_ok_n = 1'b0;
      end else if (!aux_on || card_inserted_n || aux_uv || !aux_power_request
                   || s.hot || (st.cnt[C_PGA] == PG_CYC) || force_any) begin
         next_st.out.aux_output_ok_n = 1'b1;
      end
   end

   // State register; clock enable low freezes everything
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st                      <= '0;
         // Safe power-up: switches off, outputs discharged, all status released high
         st.out.main_discharge   <= 1'b1;
         st.out.aux_discharge    <= 1'b1;
         st.out.main_trip_flag_n <= 1'b1;
         st.out.aux_trip_flag_n  <= 1'b1;
         st.out.main_output_ok_n <= 1'b1;
         st.out.aux_output_ok_n  <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign slot_out = st.out;

endmodule

`default_nettype wire

// file: verif/dsps_hpc_model.sv
// Behavioural system hot plug controller driving one slot's control pins.
// Assumes the bench changes its wishes at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module dsps_hpc_model (
   // Wishes from the bench
   input  wire logic want_card,
   input  wire logic want_main,
   input  wire logic want_aux,
   input  wire logic want_force,
   // Slot control pins
   output wire logic card_inserted_n,
   output wire logic main_power_request,
   output wire logic aux_power_request,
   output wire logic force_override
);
   // A present card pulls the start input low; without force override nothing starts before that
   assign card_inserted_n    = !want_card;
   // Requests pass straight through, so recycling them is the bench's choice
   assign main_power_request = want_main;
   assign aux_power_request  = want_aux;
   // Force pin only asserted when a scenario asks for diagnostics
   assign force_override     = want_force;
endmodule

`default_nettype wire

// file: verif/dsps_slot_properties.sv
// Concurrent checks on the ports of one power sequencer slot.
// Assumes it is bound to dsps_slot, one clock domain, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module dsps_slot_properties
   import dsps_pkg::*;
(
   // Clock and reset
   input wire logic      core_clk,
   input wire logic      rst,
   input wire logic      clk_en,
   // Control pins
   input wire logic      card_inserted_n,
   input wire logic      main_power_request,
   input wire logic      aux_power_request,
   input wire logic      force_override,
   // Front end and slot outputs
   input wire dsps_ana_s ana,
   input wire dsps_out_s slot_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [12:0] vcc_run;                          // Edges with device supply low in a row
   logic [12:0] brk_run;                          // Edges with a main breaker indication in a row

   // Run counters saturate so a long stall cannot wrap them back below a threshold;
   // they pause with the clock enable, as the slot's own filters do
   always_ff @(posedge core_clk) begin
      if (rst || !ana.lowvcc) begin
         vcc_run <= 13'h0000;
      end else if (clk_en && vcc_run != 13'h1fff) begin
         vcc_run <= vcc_run + 13'h0001;
      end
      if (rst || !(ana.brk12 || ana.brk3)) begin
         brk_run <= 13'h0000;
      end else if (clk_en && brk_run != 13'h1fff) begin
         brk_run <= brk_run + 13'h0001;
      end
   end

   card_off_a: assert property (
      clk_en && card_inserted_n && !force_override |-> ##[1:2] !slot_out.main_gate_on && !slot_out.aux_switch_on)
      else $error("Switch left on with card absent");
   main_req_a: assert property (
      clk_en && !main_power_request && !force_override |-> ##[1:2] !slot_out.main_gate_on)
      else $error("Main switch on without request");
   aux_req_a: assert property (
      clk_en && !aux_power_request && !force_override |-> ##[1:2] !slot_out.aux_switch_on)
      else $error("Aux switch on without request");
   discharge_pair_a: assert property (
      slot_out.main_discharge == !slot_out.main_gate_on && slot_out.aux_discharge == !slot_out.aux_switch_on)
      else $error("Discharge disagrees with switch state");
   ok_off_a: assert property (
      (slot_out.main_gate_on || slot_out.main_output_ok_n) && (slot_out.aux_switch_on || slot_out.aux_output_ok_n))
      else $error("Power good low with switch off");
   ok_cause_a: assert property (
      $fell(slot_out.aux_output_ok_n) |-> $past(aux_power_request && !card_inserted_n && !force_override))
      else $error("Aux power good asserted without its conditions");
   main_trip_a: assert property (
      $fell(slot_out.main_trip_flag_n) && !force_override && $past(force_override, 1) == 1'b0
      |-> brk_run >= 13'h07d0)
      else $error("Main trip before breaker filter ran out");
   vcc_off_a: assert property (
      vcc_run >= 13'h0ee2 |-> !slot_out.main_gate_on && !slot_out.aux_switch_on)
      else $error("Switch on after long device supply lockout");
   therm_off_a: assert property (
      (ana.hot && clk_en && !force_override)[*6] |-> !slot_out.aux_switch_on && !slot_out.aux_trip_flag_n)
      else $error("Aux switch not shut by over-temperature");
   force_on_a: assert property (
      (clk_en && force_override && !card_inserted_n && !ana.lowvcc)[*6] |-> slot_out.main_gate_on)
      else $error("Force override did not turn main on");

   // Main scenarios reached
   cover property (slot_out.main_gate_on && slot_out.aux_switch_on);
   cover property (!slot_out.main_trip_flag_n && slot_out.aux_switch_on);
   cover property (force_override && slot_out.main_gate_on && !main_power_request);
endmodule

`default_nettype wire

// file: verif/dsps_slot_tb.sv
// Self-checking bench for one power sequencer slot with a hot plug controller model.
// Assumes a 100 MHz clock; inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none

module dsps_slot_tb;
   import dsps_pkg::*;
   localparam dsps_ana_s ANA_OK = 12'h087;        // Supplies good, cool, no fault
   localparam int T_MID = int'(UV_CYC) - 100;     // Just short of the shortest filter
   localparam int T_END = int'(BRK_CYC) + 15;     // Past every filter but device supply
   // Outputs after a long hold with one indication flipped, brk12 first
   localparam logic [11:0][7:0] EXP_HOLD = {8'h66, 8'h66, 8'h99, 8'h99, 8'hcc, 8'h6e,
                                            8'h6e, 8'h9d, 8'hcc, 8'hce, 8'hce, 8'hcd};
   logic      core_clk;                           // Logic clock
   logic      rst;                                // Synchronous reset
   logic      clk_en;                             // Clock enable
   logic      want_card, want_main, want_aux, want_force;
   wire logic card_inserted_n, main_power_request, aux_power_request, force_override;
   dsps_ana_s ana;                                // Front-end levels
   dsps_out_s slot_out;                           // Slot outputs
   int        n_mismatch;
   int        n_compared;

   always #5 core_clk = ~core_clk;

   dsps_hpc_model i_hpc (.want_card(want_card), .want_main(want_main), .want_aux(want_aux),
      .want_force(want_force), .card_inserted_n(card_inserted_n), .main_power_request(main_power_request),
      .aux_power_request(aux_power_request), .force_override(force_override));
   dsps_slot i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .card_inserted_n(card_inserted_n),
      .main_power_request(main_power_request), .aux_power_request(aux_power_request),
      .force_override(force_override), .ana(ana), .slot_out(slot_out));

   // Compare and count
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Drop both requests, then raise them again
   task automatic recycle;
      want_main = 1'b0;
      want_aux = 1'b0;
      cyc(4);
      want_main = 1'b1;
      want_aux = 1'b1;
      cyc(6);
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Requests high before the card: nothing may start
   task automatic t_start;
      want_main = 1'b1;
      want_aux = 1'b1;
      cyc(4);
      chk("no_card", slot_out, 8'h3f);
      want_card = 1'b1;
      cyc(6);
      chk("start", slot_out, 8'hcc);
      want_card = 1'b0;
      cyc(3);
      chk("card_out", slot_out, 8'h3f);
      want_card = 1'b1;
      cyc(6);
      chk("card_back", slot_out, 8'hcc);
   endtask
   // Each indication in turn: quiet before the filters run out except hot, which acts at once, then checked after a long hold
   task automatic t_hold;
      for (int k = 0; k < 12; k++) begin
         ana = ANA_OK ^ (12'h800 >> k);
         cyc(T_MID);
         chk("filter", slot_out, (k == 3) ? 8'h99 : 8'hcc);
         cyc(T_END - T_MID);
         chk("hold", slot_out, EXP_HOLD[11 - k]);
         ana = ANA_OK;
         recycle;
         chk("recover", slot_out, 8'hcc);
      end
   endtask
   // Device supply lockout just under and over its filter
   task automatic t_vcc;
      ana = ANA_OK ^ 12'h008;
      cyc(int'(VCC_CYC) - 100);
      chk("vcc_short", slot_out, 8'hcc);
      cyc(115);
      chk("vcc_long", slot_out, 8'h3f);
      ana = ANA_OK;
      recycle;
      chk("vcc_back", slot_out, 8'hcc);
   endtask
   // Thermal restart refused while still warm
   task automatic t_thermal;
      ana = ANA_OK ^ 12'h100;
      cyc(8);
      chk("hot", slot_out, 8'h99);
      ana = ANA_OK ^ 12'h080;
      recycle;
      chk("warm_restart", {7'h00, slot_out.aux_switch_on}, 8'h00);
      ana = ANA_OK;
      recycle;
      chk("cool_restart", slot_out, 8'hcc);
   endtask
   // Diagnostic force: on without requests, breaker flagged live and unlatched
   task automatic t_force;
      want_main = 1'b0;
      want_aux = 1'b0;
      want_force = 1'b1;
      cyc(6);
      chk("force_on", slot_out, 8'hcf);
      ana = ANA_OK ^ 12'h800;
      cyc(6);
      chk("force_live", slot_out, 8'hc7);
      ana = ANA_OK;
      cyc(6);
      chk("force_unlatched", slot_out, 8'hcf);
      want_force = 1'b0;
      cyc(4);
      chk("force_off", slot_out, 8'h3f);
      recycle;
   endtask
   // Clock enable low freezes the slot
   task automatic t_freeze;
      clk_en = 1'b0;
      want_aux = 1'b0;
      cyc(5);
      chk("frozen", slot_out, 8'hcc);
      clk_en = 1'b1;
      cyc(3);
      chk("aux_drop", slot_out, 8'h9d);
      want_aux = 1'b1;
      cyc(6);
   endtask

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      clk_en = 1'b1;
      ana = ANA_OK;
      want_card = 1'b0;
      want_main = 1'b0;
      want_aux = 1'b0;
      want_force = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      cyc(10);
      rst = 1'b0;
      t_start;
      t_hold;
      t_vcc;
      t_thermal;
      t_force;
      t_freeze;
      test_done;
   end
   // Watchdog, about twice the planned run
   initial begin
      cyc(60000);
      n_mismatch++;
      test_done;
   end
endmodule

bind dsps_slot dsps_slot_properties i_props (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
   .card_inserted_n(card_inserted_n), .main_power_request(main_power_request),
   .aux_power_request(aux_power_request), .force_override(force_override), .ana(ana), .slot_out(slot_out));

`default_nettype wire
